/* File: rtl/lbm_pkg.sv */
// constants, field layouts and carrier types for the logic block model
// assumes one 50 MHz clock and an APB master with 12-bit byte addresses
//
// Summary of operation
// R1 - block takes 36 inputs, holds 16 macrocells
// R2 - block returns 32 feedback signals to interconnect
// R3 - six control terms, each sum or product
// R4 - five dedicated terms plus 32 pool terms
// R5 - pool OR matrix routes any term anywhere
// R6 - dedicated terms: programmable AND, fixed OR
// R7 - macrocell flop is D or T type
// R8 - flop captures on rising or falling edge
// R9 - fixed clock comes only from its pin
// R10 - other clocks external or macrocell generated
// R11 - two control terms drive preset and reset
// R12 - preset/reset can be disabled per macrocell
// R13 - power-up leaves every macrocell flop zero
// R14 - four control terms select output enable
// R15 - output buffer may be always on/off
// R16 - enabled global tristate low floats all outputs
// R17 - feedback before buffer and from pin
// R18 - input pin floats buffer, value reaches interconnect
// R19 - preset/reset override clocked value at once
// R20 - T type toggles when its input high
package lbm_pkg;
    localparam int unsigned LBM_NIN = 36;
    localparam int unsigned LBM_NMC = 16;
    localparam int unsigned LBM_NDED = 5;
    localparam int unsigned LBM_NPOOL = 32;
    localparam int unsigned LBM_NCT = 6;
    localparam int unsigned LBM_NCLK = 4;
    localparam int unsigned LBM_NFB = 32;
    localparam int unsigned LBM_POOL_BASE = LBM_NMC * LBM_NDED;
    localparam int unsigned LBM_CT_BASE = LBM_POOL_BASE + LBM_NPOOL;
    localparam int unsigned LBM_NTERM = LBM_CT_BASE + LBM_NCT;
    localparam int unsigned LBM_TIDX_W = 7;
    localparam int unsigned LBM_AW = 12;
    localparam int unsigned LBM_NSYNC = LBM_NMC + 1 + LBM_NCLK;
    // control term roles
    localparam int unsigned LBM_CT_PRESET = 0;
    localparam int unsigned LBM_CT_CLEAR = 1;
    localparam int unsigned LBM_CT_OE0 = 2;
    // address map
    localparam logic [11:0] LBM_POOL_ADDR = 12'h800;
    localparam logic [11:0] LBM_MCCFG_ADDR = 12'h880;
    localparam logic [11:0] LBM_CTKIND_ADDR = 12'h900;
    localparam logic [11:0] LBM_CLKCFG_ADDR = 12'h904;
    localparam logic [11:0] LBM_GTS_ADDR = 12'h908;
    localparam logic [11:0] LBM_STATE_ADDR = 12'h90c;
    localparam logic [11:0] LBM_FB_ADDR = 12'h910;
    localparam int unsigned LBM_REGION_MSB = 11;
    localparam int unsigned LBM_ARRAY_LSB = 6;
    localparam int unsigned LBM_IDX_LSB = 2;
    localparam int unsigned LBM_TERM_LSB = 4;
    // term word layout
    localparam logic [1:0] LBM_W_TRUE_LO = 2'h0;
    localparam logic [1:0] LBM_W_TRUE_HI = 2'h1;
    localparam logic [1:0] LBM_W_COMP_LO = 2'h2;
    localparam logic [1:0] LBM_W_COMP_HI = 2'h3;
    // clock config fields
    localparam int unsigned LBM_CLK_ASYNC_LSB = 0;
    localparam int unsigned LBM_CLK_SRC_LSB = 4;
    localparam int unsigned LBM_CLK_SRC_W = 4;
    // output enable selections
    localparam logic [2:0] LBM_OE_ON = 3'h4;
    localparam logic [2:0] LBM_OE_OFF = 3'h5;

    typedef struct packed {
        logic t_type;
        logic fall_edge;
        logic [1:0] clk_sel;
        logic pr_en;
        logic [2:0] oe_sel;
    } lbm_mc_cfg_t;

    localparam lbm_mc_cfg_t LBM_MC_CFG_RST = '{t_type: 1'b0, fall_edge: 1'b0, clk_sel: 2'h0,
                                               pr_en: 1'b0, oe_sel: LBM_OE_OFF};

    typedef struct packed {
        logic [11:0] addr;
        logic sel;
        logic enable;
        logic write;
        logic [31:0] wdata;
    } lbm_apb_req_t;
endpackage : lbm_pkg

/* File: rtl/lbm_term_plane.sv */
// AND-plane storage for all product and control terms, with registered evaluation
// assumes writes and reads come from the bus slave on the same clock
`timescale 1ns/10ps
`default_nettype none
module lbm_term_plane
    import lbm_pkg::*;
#(
    parameter int unsigned NTERM = LBM_NTERM,
    parameter int unsigned NIN = LBM_NIN
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // configuration access
    input wire logic wr_en,
    input wire logic [LBM_TIDX_W-1:0] wr_term,
    input wire logic [1:0] wr_word,
    input wire logic [31:0] wr_data,
    input wire logic [LBM_TIDX_W-1:0] rd_term,
    input wire logic [1:0] rd_word,
    output logic [31:0] rd_data,
    // evaluation
    input wire logic [NIN-1:0] in_vec,
    input wire logic [NTERM-1:0] sum_kind,
    output logic [NTERM-1:0] term_out
);
    localparam int unsigned HIW = NIN - 32;

    logic [NIN-1:0] true_mask [NTERM];
    logic [NIN-1:0] comp_mask [NTERM];
    logic [31:0] rd_next;
    logic [NIN-1:0] rd_t;
    logic [NIN-1:0] rd_c;
    wire rd_ok = 32'(rd_term) < NTERM;
    wire wr_ok = 32'(wr_term) < NTERM;

    assign rd_t = rd_ok ? true_mask[rd_term] : '0;
    assign rd_c = rd_ok ? comp_mask[rd_term] : '0;
    assign rd_next = (rd_word == LBM_W_TRUE_LO) ? rd_t[31:0] :
                     (rd_word == LBM_W_TRUE_HI) ? {{(32-HIW){1'b0}}, rd_t[NIN-1:32]} :
                     (rd_word == LBM_W_COMP_LO) ? rd_c[31:0] :
                     {{(32-HIW){1'b0}}, rd_c[NIN-1:32]};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data <= '0;
            for (int i = 0; i < NTERM; i++)
            begin
                true_mask[i] <= '0;
                comp_mask[i] <= '0;
            end
        end
        else
        begin
            rd_data <= rd_next;
            if (wr_en && wr_ok)
            begin
                unique case (wr_word)
                    LBM_W_TRUE_LO: true_mask[wr_term][31:0] <= wr_data;
                    LBM_W_TRUE_HI: true_mask[wr_term][NIN-1:32] <= wr_data[HIW-1:0];
                    LBM_W_COMP_LO: comp_mask[wr_term][31:0] <= wr_data;
                    LBM_W_COMP_HI: comp_mask[wr_term][NIN-1:32] <= wr_data[HIW-1:0];
                endcase
            end
        end
    end

    // a term with no literal selected reads as zero
    for (genvar t = 0; t < NTERM; t++)
    begin : g_term
        wire used = |(true_mask[t] | comp_mask[t]);
        wire as_sum = |((in_vec & true_mask[t]) | (~in_vec & comp_mask[t])); // R3
        wire as_prod = &((~true_mask[t] | in_vec) & (~comp_mask[t] | ~in_vec)); // R6
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                term_out[t] <= 1'b0;
            else
                term_out[t] <= used & (sum_kind[t] ? as_sum : as_prod); // R3
        end
    end
endmodule : lbm_term_plane
`default_nettype wire

/* File: rtl/lbm_logic_block.sv */
// one logic block: term plane, shared pool, 16 macrocells, clocks, output control
// assumes an APB master on ref_clk; pins and external clocks are asynchronous
`timescale 1ns/10ps
`default_nettype none
module lbm_logic_block
    import lbm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [LBM_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interconnect side
    input wire logic [LBM_NIN-1:0] gia_in,
    output logic [LBM_NFB-1:0] gia_fb,
    // clock pins
    input wire logic fixed_external_clock,
    input wire logic flexible_clock_one,
    input wire logic flexible_clock_two,
    input wire logic flexible_clock_three,
    // global three-state
    input wire logic global_tristate_pin,
    // macrocell pins
    input wire logic [LBM_NMC-1:0] pin_in,
    output logic [LBM_NMC-1:0] pin_out,
    output logic [LBM_NMC-1:0] pin_oe_n
);
    // pin synchronisers
    logic [LBM_NSYNC-1:0] sync1_reg;
    logic [LBM_NSYNC-1:0] sync2_reg;
    wire [LBM_NSYNC-1:0] async_pins = {flexible_clock_three, flexible_clock_two, flexible_clock_one,
                                       fixed_external_clock, global_tristate_pin, pin_in};
    wire [LBM_NMC-1:0] pin_sync = sync2_reg[LBM_NMC-1:0];
    wire gts_sync = sync2_reg[LBM_NMC];
    wire [LBM_NCLK-1:0] clk_pin_sync = sync2_reg[LBM_NSYNC-1 -: LBM_NCLK];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= async_pins;
            sync2_reg <= sync1_reg;
        end
    end

    // configuration state
    logic [LBM_NPOOL-1:0] pool_sel_reg [LBM_NMC];
    lbm_mc_cfg_t mc_cfg_reg [LBM_NMC];
    logic [LBM_NCT-1:0] ct_kind_reg;
    logic [15:0] clk_cfg_reg;
    logic gts_en_reg;
    logic [LBM_NMC-1:0] mc_q_reg;
    logic [LBM_NFB-1:0] gia_fb_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [LBM_NMC-1:0] pin_out_reg;
    logic [LBM_NMC-1:0] pin_oe_n_reg;
    logic [LBM_NTERM-1:0] term_q;
    logic [31:0] plane_rd;

    // apb request carrier and decode
    lbm_apb_req_t req;
    assign req = '{addr: paddr, sel: psel, enable: penable, write: pwrite, wdata: pwdata};

    wire apb_acc = req.sel & req.enable & ~pready_reg;
    wire apb_done = req.sel & req.enable & pready_reg;
    wire wr_go = apb_done & req.write;
    wire [LBM_TIDX_W-1:0] a_term = req.addr[LBM_REGION_MSB-1:LBM_TERM_LSB];
    wire [1:0] a_word = req.addr[LBM_TERM_LSB-1:LBM_IDX_LSB];
    wire [3:0] a_idx = req.addr[LBM_ARRAY_LSB-1:LBM_IDX_LSB];
    wire [LBM_AW-1:LBM_ARRAY_LSB] a_blk = req.addr[LBM_AW-1:LBM_ARRAY_LSB];
    wire hit_term = ~req.addr[LBM_REGION_MSB] && (32'(a_term) < LBM_NTERM);
    wire hit_pool = a_blk == LBM_POOL_ADDR[LBM_AW-1:LBM_ARRAY_LSB];
    wire hit_mccfg = a_blk == LBM_MCCFG_ADDR[LBM_AW-1:LBM_ARRAY_LSB];
    wire hit_ctkind = req.addr == LBM_CTKIND_ADDR;
    wire hit_clkcfg = req.addr == LBM_CLKCFG_ADDR;
    wire hit_gts = req.addr == LBM_GTS_ADDR;
    wire hit_state = req.addr == LBM_STATE_ADDR;
    wire hit_fb = req.addr == LBM_FB_ADDR;
    wire hit_any = hit_term | hit_pool | hit_mccfg | hit_ctkind | hit_clkcfg | hit_gts | hit_state | hit_fb;

    wire [31:0] rd_mux = hit_term ? plane_rd :
                         hit_pool ? pool_sel_reg[a_idx] :
                         hit_mccfg ? {24'h000000, mc_cfg_reg[a_idx]} :
                         hit_ctkind ? {{(32-LBM_NCT){1'b0}}, ct_kind_reg} :
                         hit_clkcfg ? {16'h0000, clk_cfg_reg} :
                         hit_gts ? {31'h00000000, gts_en_reg} :
                         hit_state ? {{(32-LBM_NMC){1'b0}}, mc_q_reg} :
                         hit_fb ? gia_fb_reg :
                         32'h00000000;

    // one wait state: ready the cycle after the access phase starts
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= apb_acc;
            if (apb_acc)
            begin
                prdata_reg <= req.write ? 32'h00000000 : rd_mux;
                pslverr_reg <= ~hit_any;
            end
            else
                pslverr_reg <= 1'b0;
        end
    end

    // configuration writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ct_kind_reg <= '0;
            clk_cfg_reg <= '0;
            gts_en_reg <= 1'b0;
            for (int i = 0; i < LBM_NMC; i++)
            begin
                pool_sel_reg[i] <= '0;
                mc_cfg_reg[i] <= LBM_MC_CFG_RST;
            end
        end
        else if (wr_go)
        begin
            if (hit_pool)
                pool_sel_reg[a_idx] <= req.wdata; // R5
            if (hit_mccfg)
                mc_cfg_reg[a_idx] <= req.wdata[7:0];
            if (hit_ctkind)
                ct_kind_reg <= req.wdata[LBM_NCT-1:0]; // R3
            if (hit_clkcfg)
                clk_cfg_reg <= req.wdata[15:0];
            if (hit_gts)
                gts_en_reg <= req.wdata[0];
        end
    end

    // term plane: dedicated, pool and control terms in one array
    wire [LBM_NTERM-1:0] sum_kind = {ct_kind_reg, {(LBM_NTERM-LBM_NCT){1'b0}}};

    lbm_term_plane #(
        .NTERM(LBM_NTERM),
        .NIN(LBM_NIN)
    ) u_plane (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(wr_go & hit_term),
        .wr_term(a_term),
        .wr_word(a_word),
        .wr_data(req.wdata),
        .rd_term(a_term),
        .rd_word(a_word),
        .rd_data(plane_rd),
        .in_vec(gia_in), // R1
        .sum_kind(sum_kind),
        .term_out(term_q)
    );

    wire [LBM_NPOOL-1:0] pool_terms = term_q[LBM_POOL_BASE +: LBM_NPOOL];
    wire [LBM_NCT-1:0] ct_terms = term_q[LBM_CT_BASE +: LBM_NCT];
    wire gts_float = gts_en_reg & ~gts_sync; // R16

    // clock selection; clock 0 is pin only
    logic [LBM_NCLK-1:0] clk_lvl;
    logic [LBM_NCLK-1:0] clk_prev_reg;
    assign clk_lvl[0] = clk_pin_sync[0]; // R9

    for (genvar c = 1; c < LBM_NCLK; c++)
    begin : g_clk
        wire use_async = clk_cfg_reg[LBM_CLK_ASYNC_LSB + c - 1];
        wire [LBM_CLK_SRC_W-1:0] src = clk_cfg_reg[LBM_CLK_SRC_LSB + (c-1)*LBM_CLK_SRC_W +: LBM_CLK_SRC_W];
        assign clk_lvl[c] = use_async ? mc_q_reg[src] : clk_pin_sync[c]; // R10
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            clk_prev_reg <= '0;
        else
            clk_prev_reg <= clk_lvl;
    end

    wire [LBM_NCLK-1:0] clk_rise = clk_lvl & ~clk_prev_reg;
    wire [LBM_NCLK-1:0] clk_fall = ~clk_lvl & clk_prev_reg;

    // macrocells
    for (genvar m = 0; m < LBM_NMC; m++)
    begin : g_mc
        lbm_mc_cfg_t cfg;
        assign cfg = mc_cfg_reg[m];
        wire ded_sum = |term_q[m*LBM_NDED +: LBM_NDED]; // R4 R6
        wire pool_sum = |(pool_terms & pool_sel_reg[m]); // R4 R5
        wire d_in = ded_sum | pool_sum;
        wire fire = cfg.fall_edge ? clk_fall[cfg.clk_sel] : clk_rise[cfg.clk_sel]; // R8
        wire preset = cfg.pr_en & ct_terms[LBM_CT_PRESET]; // R11 R12
        wire clear = cfg.pr_en & ct_terms[LBM_CT_CLEAR]; // R11 R12
        wire clocked = cfg.t_type ? (mc_q_reg[m] ^ d_in) : d_in; // R7 R20
        wire q_next = clear ? 1'b0 :
                      preset ? 1'b1 :
                      fire ? clocked :
                      mc_q_reg[m]; // R19
        wire oe_ct = ct_terms[LBM_CT_OE0 + 32'(cfg.oe_sel[1:0])]; // R14
        wire oe_cfg = cfg.oe_sel[2] ? (cfg.oe_sel == LBM_OE_ON) : oe_ct; // R15
        wire drive = oe_cfg & ~gts_float; // R16 R18

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                mc_q_reg[m] <= 1'b0; // R13
                pin_out_reg[m] <= 1'b0;
                pin_oe_n_reg[m] <= 1'b1;
            end
            else
            begin
                mc_q_reg[m] <= q_next;
                pin_out_reg[m] <= q_next;
                pin_oe_n_reg[m] <= ~drive;
            end
        end
    end

    // feedback: macrocell path below, pin path above
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            gia_fb_reg <= '0;
        else
            gia_fb_reg <= {pin_sync, mc_q_reg}; // R2 R17 R18
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign gia_fb = gia_fb_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;
endmodule : lbm_logic_block
`default_nettype wire

/* File: bench/lbm_logic_block_chk.sv */
// checker: apb timing, reset state and both feedback paths of the logic block
// bound to every lbm_logic_block instance; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module lbm_logic_block_chk
    import lbm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // block side
    input wire logic [LBM_NFB-1:0] gia_fb,
    input wire logic [LBM_NMC-1:0] pin_in,
    input wire logic [LBM_NMC-1:0] pin_out,
    input wire logic [LBM_NMC-1:0] pin_oe_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_hold: assert property (!pready |=> pready || $stable(prdata))
        else $error("prdata changed between transfers");
    a_reset_clean: assert property ($rose(rst_n) |-> pin_out == '0 && pin_oe_n == '1 && gia_fb[15:0] == '0)
        else $error("flops or buffers not clear after reset");
    a_fb_macro: assert property (gia_fb[LBM_NMC-1:0] == $past(pin_out))
        else $error("macrocell feedback does not follow the flop");
    a_fb_pin: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |-> gia_fb[31:16] == $past(pin_in, 3))
        else $error("pin feedback does not follow the pad");
endmodule : lbm_logic_block_chk
bind lbm_logic_block lbm_logic_block_chk u_chk (.ref_clk, .rst_n, .psel, .penable, .prdata, .pready, .pslverr,
    .gia_fb, .pin_in, .pin_out, .pin_oe_n);
`default_nettype wire

/* File: bench/lbm_pins_model.sv */
// board side: clock pins, global three-state pin and pad resolution
// assumes the bench sets clk_lvl, gts_lvl, ext_val and ext_en after a rising edge
`timescale 1ns/10ps
`default_nettype none
module lbm_pins_model
    import lbm_pkg::*;
(
    // clock and three-state pins
    output logic fixed_external_clock,
    output logic flexible_clock_one,
    output logic flexible_clock_two,
    output logic flexible_clock_three,
    output logic global_tristate_pin,
    // pads
    input wire logic [LBM_NMC-1:0] pin_out,
    input wire logic [LBM_NMC-1:0] pin_oe_n,
    output logic [LBM_NMC-1:0] pin_in
);
    logic [3:0] clk_lvl = 4'h0;
    logic gts_lvl = 1'b1;
    logic [LBM_NMC-1:0] ext_val = '0;
    logic [LBM_NMC-1:0] ext_en = '0;
    // clocks idle low between bursts; the fixed clock only ever comes from here
    assign fixed_external_clock = clk_lvl[0];
    assign flexible_clock_one = clk_lvl[1];
    assign flexible_clock_two = clk_lvl[2];
    assign flexible_clock_three = clk_lvl[3];
    assign global_tristate_pin = gts_lvl;
    // a pad nobody drives shows the inverse of its current pin_out level
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_en & ext_val) | (~ext_en & ~pin_out)));
endmodule : lbm_pins_model
`default_nettype wire

/* File: bench/lbm_logic_block_tb.sv */
// self-checking bench for the logic block: registers over apb, flops, pool, control terms, pads
// assumes the board model drives clock pins, three-state pin and pads
`timescale 1ns/10ps
`default_nettype none
module lbm_logic_block_tb
    import lbm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [LBM_AW-1:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rd_err;
    logic [31:0] pwdata = '0, prdata, rd_val;
    logic [LBM_NIN-1:0] gia_in = '0;
    logic [LBM_NFB-1:0] gia_fb;
    wire fixed_external_clock, flexible_clock_one, flexible_clock_two, flexible_clock_three, global_tristate_pin;
    wire [LBM_NMC-1:0] pin_in, pin_out, pin_oe_n;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #10 ref_clk = ~ref_clk;

    lbm_logic_block u_lbm_logic_block (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .gia_in, .gia_fb, .fixed_external_clock, .flexible_clock_one, .flexible_clock_two,
        .flexible_clock_three, .global_tristate_pin, .pin_in, .pin_out, .pin_oe_n);
    lbm_pins_model u_lbm_pins_model (.fixed_external_clock, .flexible_clock_one, .flexible_clock_two,
        .flexible_clock_three, .global_tristate_pin, .pin_out, .pin_oe_n, .pin_in);

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // wait for the slave; only the bench timeout ends a hung access
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk(rd_err, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_val, exp);
    endtask : rd

    task automatic lvl(input int i, input logic v);
        @(posedge ref_clk);
        u_lbm_pins_model.clk_lvl[i] <= v;
        repeat (6) @(posedge ref_clk);
    endtask : lvl

    task automatic gin(input int i, input logic v);
        @(posedge ref_clk);
        gia_in[i] <= v;
        repeat (3) @(posedge ref_clk);
    endtask : gin

    task automatic t_regs();
        rd(LBM_MCCFG_ADDR, 32'h5);
        rd(LBM_GTS_ADDR, 32'h0);
        wr(LBM_STATE_ADDR, 32'hffff);
        rd(LBM_STATE_ADDR, 32'h0);
        wr(12'h004, 32'hffffffff);
        rd(12'h004, 32'hf);
        wr(12'h004, 32'h0);
        wr(LBM_CTKIND_ADDR, 32'hffffffff);
        rd(LBM_CTKIND_ADDR, 32'h3f);
        wr(LBM_CTKIND_ADDR, 32'h0);
        apb(1'b0, 12'h914, 32'h0);
        chk(rd_err, 1'b1);
        apb(1'b1, 12'hffc, 32'h1);
        chk(rd_err, 1'b1);
        $display("test regs done");
    endtask : t_regs

    task automatic t_flops();
        wr(12'h000, 32'h1);
        wr(12'h050, 32'h2);
        wr(12'h0a0, 32'h4);
        wr(LBM_MCCFG_ADDR, 32'h04);
        wr(12'h884, 32'h84);
        wr(12'h888, 32'h44);
        gin(0, 1'b1);
        gin(1, 1'b1);
        gin(2, 1'b1);
        chk(pin_out[2:0], 3'h0);
        chk(pin_oe_n[0], 1'b0);
        lvl(0, 1'b1);
        chk(pin_out[2:0], 3'h3);
        gin(0, 1'b0);
        lvl(0, 1'b0);
        chk(pin_out[2:0], 3'h7);
        lvl(0, 1'b1);
        chk(pin_out[2:0], 3'h4);
        gin(1, 1'b0);
        lvl(0, 1'b0);
        lvl(0, 1'b1);
        chk(pin_out[2:0], 3'h4);
        lvl(0, 1'b0);
        $display("test flops done");
    endtask : t_flops

    task automatic t_pool();
        wr(12'h500, 32'h8);
        wr(12'h80c, 32'h1);
        wr(12'h810, 32'h1);
        wr(12'h88c, 32'h04);
        wr(12'h890, 32'h04);
        gin(3, 1'b1);
        lvl(0, 1'b1);
        chk(pin_out[4:3], 2'h3);
        lvl(0, 1'b0);
        $display("test pool done");
    endtask : t_pool

    task automatic t_setclr();
        wr(12'h700, 32'h10);
        wr(12'h710, 32'h20);
        wr(12'h894, 32'h0c);
        wr(12'h898, 32'h04);
        gin(4, 1'b1);
        chk(pin_out[6:5], 2'h1);
        gin(5, 1'b1);
        chk(pin_out[6:5], 2'h0);
        gin(4, 1'b0);
        gin(5, 1'b0);
        $display("test setclr done");
    endtask : t_setclr

    task automatic t_oe();
        wr(12'h720, 32'hc0);
        wr(12'h89c, 32'h00);
        gin(6, 1'b1);
        chk(pin_oe_n[7], 1'b1);
        gin(7, 1'b1);
        chk(pin_oe_n[7], 1'b0);
        gin(6, 1'b0);
        chk(pin_oe_n[7], 1'b1);
        wr(LBM_CTKIND_ADDR, 32'h4);
        repeat (3) @(posedge ref_clk);
        chk(pin_oe_n[7], 1'b0);
        gin(7, 1'b0);
        chk(pin_oe_n[7], 1'b1);
        $display("test oe done");
    endtask : t_oe

    task automatic t_gts();
        wr(LBM_GTS_ADDR, 32'h1);
        @(posedge ref_clk);
        u_lbm_pins_model.gts_lvl <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk(pin_oe_n, 16'hffff);
        wr(LBM_GTS_ADDR, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk(pin_oe_n[0], 1'b0);
        u_lbm_pins_model.gts_lvl <= 1'b1;
        $display("test gts done");
    endtask : t_gts

    task automatic t_pads();
        @(posedge ref_clk);
        u_lbm_pins_model.ext_en[8] <= 1'b1;
        u_lbm_pins_model.ext_val[8] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk({pin_oe_n[8], gia_fb[24]}, 2'h3);
        u_lbm_pins_model.ext_val[8] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk({gia_fb[24], gia_fb[8]}, 2'h0);
        chk({gia_fb[19], gia_fb[3]}, 2'h3);
        $display("test pads done");
    endtask : t_pads

    task automatic t_async();
        // clock 1 from macrocell 0, clock 3 from macrocell 9
        wr(LBM_CLKCFG_ADDR, 32'h9005);
        wr(12'h2d0, 32'h200);
        wr(12'h320, 32'h400);
        wr(12'h370, 32'h800);
        wr(12'h8a4, 32'h14);
        wr(12'h8a8, 32'h24);
        wr(12'h8ac, 32'h34);
        gin(9, 1'b1);
        gin(10, 1'b1);
        gin(11, 1'b1);
        chk(pin_out[11:9], 3'h0);
        gin(0, 1'b1);
        lvl(0, 1'b1);
        chk(pin_out[11:9], 3'h5);
        lvl(2, 1'b1);
        chk(pin_out[11:9], 3'h7);
        lvl(2, 1'b0);
        lvl(0, 1'b0);
        $display("test async done");
    endtask : t_async

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_flops();
        t_pool();
        t_setclr();
        t_oe();
        t_gts();
        t_pads();
        t_async();
        test_done();
    end
endmodule : lbm_logic_block_tb
`default_nettype wire
